// ===== core/sfds_core.sv
// SPI character engine: formats, clock modes, interrupt lines, DMA events, loopback, self-test.
// Assumes one 125 MHz clock, a 32-bit Avalon-MM master, and serial pins resolved outside.
//
// How it works
// - Received character right-aligned, upper bits zero.
// - Order bit 0 sends MSB first, per format.
// - Order bit 1 sends LSB first.
// - Phase one drives first bit before clocking.
// - Pol0 pha0: launch rising, capture falling.
// - Pol0 pha1: early first bit, capture rising.
// - Pol1 pha0: launch falling, capture rising.
// - Pol1 pha1: early first bit, capture falling.
// - Master starts clocking on transmit write.
// - Level register routes events to line one.
// - Per-event enables gate interrupt lines.
// - Occurred events held as readable flags.
// - Vector register names pending line-one source.
// - Two DMA requests, only when enabled.
// - Transmit request pulses when buffer frees.
// - Receive request pulses per received character.
// - Loopback, in master role only, feeds back, releases all pins.
// - Own driven pin sampled and compared.
// - Mismatch sets status, flag, error interrupt.
// - Self-test off during loopback.
// - Per-format length, two to sixteen bits.
// - Transmit write selects its format.
module sfds_core
    import sfds_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic [ADDR_W-1:0] avs_address, // Register byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Write byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic sclkIn, // Serial clock pin level
    output logic sclkOut, // Serial clock drive
    output logic sclkOeN, // Serial clock enable, low drives
    input wire logic mosiIn, // Master-out pin level
    output logic mosiOut, // Master-out drive
    output logic mosiOeN, // Master-out enable, low drives
    input wire logic misoIn, // Master-in pin level
    output logic misoOut, // Master-in drive
    output logic misoOeN, // Master-in enable, low drives
    output logic irqLine0, // Level-zero interrupt
    output logic irqLine1, // Level-one interrupt
    output logic rxDmaReq, // Receive DMA request pulse
    output logic txDmaReq // Transmit DMA request pulse
);

    logic [31:0] ctrl_ff, intEn_ff, level_ff, rdData_ff, curFmt_ff;
    logic [31:0] fmt_ff [NUM_FMT];
    logic [DATA_W-1:0] txBuf_ff, rxBuf_ff, txShift_ff, rxAcc_ff, nxt_rxAcc;
    logic [1:0] txSel_ff;
    logic txPend_ff, rxFull_ff, rxBitErr_ff, bitErrFlag_ff, waitReq_ff, sclkLvl_ff, dataOut_ff;
    sfds_state_type state_ff;
    logic [4:0] outIdx_ff, capCnt_ff, curLen;
    logic [5:0] edgeCnt_ff;
    logic [8:0] halfCnt_ff;
    logic sclkS1_ff, sclkS2_ff, sclkD_ff, mosiS1_ff, mosiS2_ff, misoS1_ff, misoS2_ff;
    logic dmaEnD_ff, irq0_ff, irq1_ff, rxDma_ff, txDma_ff, sclkOeN_ff, mosiOeN_ff, misoOeN_ff;

    logic wrAcc, rdAcc, isMaster, isLoop, isOn, dmaEn;
    logic start, edgeEv, newLvl, isCap, done, rxIn, ownPin;
    logic [31:0] wMask, flags, pending0, pending1, startFmt;

    function automatic logic [4:0] eff_len(input logic [FMT_LEN_W-1:0] raw);
        logic [4:0] res;
        res = raw;
        if (raw < CHAR_MIN) begin
            res = CHAR_MIN;
        end else if (raw > CHAR_MAX) begin
            res = CHAR_MAX;
        end
        return res;
    endfunction : eff_len

    // Bit position for the idx-th serial bit of a right-aligned character
    function automatic logic [3:0] bit_pos(input logic [4:0] len, input logic lsbFirst, input logic [4:0] idx);
        logic [4:0] p;
        p = lsbFirst ? idx : 5'(len - idx - 5'h01);
        return p[3:0];
    endfunction : bit_pos

    function automatic logic [4:0] vec_of(input logic [31:0] pend);
        logic [4:0] v;
        v = VEC_NONE;
        if (pend[EVT_BIT_MISMATCH_STATUS]) begin
            v = VEC_BIT_MISMATCH_STATUS;
        end else if (pend[EVT_RX]) begin
            v = VEC_RX;
        end else if (pend[EVT_TX]) begin
            v = VEC_TX;
        end
        return v;
    endfunction : vec_of

    assign isMaster = ctrl_ff[CTRL_MASTER];
    assign isLoop = ctrl_ff[CTRL_LOOPBACK] & ctrl_ff[CTRL_MASTER];
    assign isOn = ctrl_ff[CTRL_ENABLE];
    assign dmaEn = intEn_ff[INTEN_DMA];
    assign wrAcc = avs_write & ~waitReq_ff;
    assign rdAcc = avs_read & ~waitReq_ff;
    assign wMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign curLen = eff_len(curFmt_ff[FMT_LEN_LSB +: FMT_LEN_W]);
    assign startFmt = fmt_ff[txSel_ff];
    assign start = (state_ff == ST_IDLE) & isOn & txPend_ff;

    assign flags = {22'h00_0000, ~txPend_ff, rxFull_ff, 7'h00, bitErrFlag_ff};
    assign pending0 = flags & intEn_ff & ~level_ff;
    assign pending1 = flags & intEn_ff & level_ff;

    // Edge source: own divider as master, synchronised pin as slave
    assign newLvl = isMaster ? ~sclkLvl_ff : sclkS2_ff;
    assign edgeEv = (state_ff == ST_SHIFT) & (isMaster ? (halfCnt_ff == 9'h000) : (sclkS2_ff != sclkD_ff));
    // capture edge is rising exactly when pol differs from pha
    assign isCap = newLvl == (curFmt_ff[FMT_POL] ^ curFmt_ff[FMT_PHA]);
    // loopback takes the transmit stream internally
    assign rxIn = isLoop ? dataOut_ff : (isMaster ? misoS2_ff : mosiS2_ff);
    // only the pin driven in the current role
    assign ownPin = isMaster ? mosiS2_ff : misoS2_ff;
    assign done = edgeEv & (isMaster ? (edgeCnt_ff == 6'({curLen, 1'b0} - 6'h01))
                                     : (isCap & (capCnt_ff == 5'(curLen - 5'h01))));

    // accumulator starts at zero so unused upper bits stay zero
    always_comb begin
        nxt_rxAcc = rxAcc_ff;
        if (edgeEv & isCap) begin
            nxt_rxAcc[bit_pos(curLen, curFmt_ff[FMT_ORDER], capCnt_ff)] = rxIn;
        end
    end

    // Pin synchronisers; the first stage feeds only the second
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclkS1_ff <= 1'b0;
            sclkS2_ff <= 1'b0;
            sclkD_ff <= 1'b0;
            mosiS1_ff <= 1'b0;
            mosiS2_ff <= 1'b0;
            misoS1_ff <= 1'b0;
            misoS2_ff <= 1'b0;
        end else begin
            sclkS1_ff <= sclkIn;
            sclkS2_ff <= sclkS1_ff;
            sclkD_ff <= sclkS2_ff;
            mosiS1_ff <= mosiIn;
            mosiS2_ff <= mosiS1_ff;
            misoS1_ff <= misoIn;
            misoS2_ff <= misoS1_ff;
        end
    end

    // Bus handshake: one wait cycle, then the access completes
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            waitReq_ff <= 1'b1;
        end else begin
            waitReq_ff <= ~((avs_read | avs_write) & waitReq_ff);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdData_ff <= RST_WORD;
        end else if (avs_read & waitReq_ff) begin
            unique case (avs_address)
                OFF_CTRL: rdData_ff <= ctrl_ff;
                OFF_INTEN: rdData_ff <= intEn_ff;
                OFF_LEVEL: rdData_ff <= level_ff;
                OFF_FLAG: rdData_ff <= flags;
                OFF_FMT0: rdData_ff <= fmt_ff[0];
                OFF_FMT1: rdData_ff <= fmt_ff[1];
                OFF_FMT2: rdData_ff <= fmt_ff[2];
                OFF_FMT3: rdData_ff <= fmt_ff[3];
                OFF_TXDATA: rdData_ff <= {6'h00, txSel_ff, 8'h00, txBuf_ff};
                OFF_RXBUF: rdData_ff <= {rxFull_ff, 2'b00, rxBitErr_ff, 12'h000, rxBuf_ff};
                OFF_VEC0: rdData_ff <= {27'h000_0000, vec_of(pending0)};
                OFF_VEC1: rdData_ff <= {27'h000_0000, vec_of(pending1)};
                default: rdData_ff <= RST_WORD;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_ff <= RST_WORD;
            intEn_ff <= RST_WORD;
            level_ff <= RST_WORD;
        end else if (wrAcc) begin
            if (avs_address == OFF_CTRL) begin
                ctrl_ff <= (ctrl_ff & ~wMask) | (avs_writedata & wMask);
            end
            if (avs_address == OFF_INTEN) begin
                intEn_ff <= (intEn_ff & ~wMask) | (avs_writedata & wMask);
            end
            if (avs_address == OFF_LEVEL) begin
                level_ff <= (level_ff & ~wMask) | (avs_writedata & wMask);
            end
        end
    end

    for (genvar g = 0; g < NUM_FMT; g++) begin : gFmt
        always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
                fmt_ff[g] <= RST_WORD;
            end else if (wrAcc && avs_address == 6'(OFF_FMT0 + 6'(4 * g))) begin
                fmt_ff[g] <= (fmt_ff[g] & ~wMask) | (avs_writedata & wMask);
            end
        end
    end

    // transmit word holds data and its format choice
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            txBuf_ff <= 16'h0000;
            txSel_ff <= 2'b00;
            txPend_ff <= 1'b0;
        end else if (wrAcc && avs_address == OFF_TXDATA) begin
            if (avs_byteenable[0]) txBuf_ff[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1]) txBuf_ff[15:8] <= avs_writedata[15:8];
            if (avs_byteenable[3]) txSel_ff <= avs_writedata[TX_FSEL_LSB +: 2];
            txPend_ff <= 1'b1;
        end else if (start) begin
            txPend_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE: if (start) state_ff <= ST_SHIFT;
                ST_SHIFT: if (done || !isOn) state_ff <= ST_IDLE;
            endcase
        end
    end

    // Half-period divider for the generated serial clock
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            halfCnt_ff <= 9'h000;
        end else if (start || (edgeEv && isMaster)) begin
            halfCnt_ff <= 9'({1'b0, (start ? startFmt[FMT_PRE_LSB +: FMT_PRE_W] : curFmt_ff[FMT_PRE_LSB +: FMT_PRE_W])}
                + MIN_HALF - 9'h001);
        end else if (halfCnt_ff != 9'h000) begin
            halfCnt_ff <= halfCnt_ff - 9'h001;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclkLvl_ff <= 1'b0;
        end else if (state_ff == ST_IDLE) begin
            sclkLvl_ff <= start ? startFmt[FMT_POL] : curFmt_ff[FMT_POL];
        end else if (edgeEv && isMaster) begin
            sclkLvl_ff <= ~sclkLvl_ff;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            curFmt_ff <= RST_WORD;
            txShift_ff <= 16'h0000;
            edgeCnt_ff <= 6'h00;
        end else if (start) begin
            curFmt_ff <= startFmt;
            txShift_ff <= txBuf_ff;
            edgeCnt_ff <= 6'h00;
        end else if (edgeEv) begin
            edgeCnt_ff <= edgeCnt_ff + 6'h01;
        end
    end

    // Launch side: order per format, first bit early with phase one
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dataOut_ff <= 1'b0;
            outIdx_ff <= 5'h00;
        end else if (start) begin
            if (startFmt[FMT_PHA]) begin
                dataOut_ff <= txBuf_ff[bit_pos(eff_len(startFmt[FMT_LEN_LSB +: FMT_LEN_W]), startFmt[FMT_ORDER], 5'h00)];
                outIdx_ff <= 5'h01;
            end else begin
                outIdx_ff <= 5'h00;
            end
        end else if (edgeEv && !isCap && outIdx_ff < curLen) begin
            // launch on the edge opposite to capture
            dataOut_ff <= txShift_ff[bit_pos(curLen, curFmt_ff[FMT_ORDER], outIdx_ff)];
            outIdx_ff <= outIdx_ff + 5'h01;
        end
    end

    // Capture side
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rxAcc_ff <= 16'h0000;
            capCnt_ff <= 5'h00;
        end else if (start) begin
            rxAcc_ff <= 16'h0000;
            capCnt_ff <= 5'h00;
        end else if (edgeEv && isCap) begin
            rxAcc_ff <= nxt_rxAcc;
            capCnt_ff <= capCnt_ff + 5'h01;
        end
    end

    // buffer loads the right-aligned character; a read clears the new-data flag, set wins
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rxBuf_ff <= 16'h0000;
            rxFull_ff <= 1'b0;
        end else if (done) begin
            rxBuf_ff <= nxt_rxAcc;
            rxFull_ff <= 1'b1;
        end else if (rdAcc && avs_address == OFF_RXBUF) begin
            rxFull_ff <= 1'b0;
        end
    end

    // compare own pin at each capture, never in loopback
    // status in buffer and sticky flag; flag is write-one-to-clear, set wins
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rxBitErr_ff <= 1'b0;
            bitErrFlag_ff <= 1'b0;
        end else if (edgeEv && isCap && !isLoop && ownPin != dataOut_ff) begin
            rxBitErr_ff <= 1'b1;
            bitErrFlag_ff <= 1'b1;
        end else begin
            if (rdAcc && avs_address == OFF_RXBUF) begin
                rxBitErr_ff <= 1'b0;
            end
            if (wrAcc && avs_address == OFF_FLAG && avs_byteenable[0] && avs_writedata[EVT_BIT_MISMATCH_STATUS]) begin
                bitErrFlag_ff <= 1'b0;
            end
        end
    end

    // interrupt lines; DMA pulses gated by the request enable
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq0_ff <= 1'b0;
            irq1_ff <= 1'b0;
            dmaEnD_ff <= 1'b0;
            rxDma_ff <= 1'b0;
            txDma_ff <= 1'b0;
        end else begin
            irq0_ff <= |pending0;
            irq1_ff <= |pending1;
            dmaEnD_ff <= dmaEn;
            rxDma_ff <= dmaEn & done;
            txDma_ff <= dmaEn & (start | (~dmaEnD_ff & ~txPend_ff));
        end
    end

    // loopback releases all three pins; master drives clock and data-out, slave data-in
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclkOeN_ff <= 1'b1;
            mosiOeN_ff <= 1'b1;
            misoOeN_ff <= 1'b1;
        end else begin
            sclkOeN_ff <= ~(isOn & isMaster & ~isLoop);
            mosiOeN_ff <= ~(isOn & isMaster & ~isLoop);
            misoOeN_ff <= ~(isOn & ~isMaster);
        end
    end

    assign avs_readdata = rdData_ff;
    assign avs_waitrequest = waitReq_ff;
    assign sclkOut = sclkLvl_ff;
    assign sclkOeN = sclkOeN_ff;
    assign mosiOut = dataOut_ff;
    assign mosiOeN = mosiOeN_ff;
    assign misoOut = dataOut_ff;
    assign misoOeN = misoOeN_ff;
    assign irqLine0 = irq0_ff;
    assign irqLine1 = irq1_ff;
    assign rxDmaReq = rxDma_ff;
    assign txDmaReq = txDma_ff;

endmodule : sfds_core

// ===== core/sfds_pkg.sv
// Constants for the SPI character shifter with format, DMA-event and self-test logic.
// Assumes a 32-bit Avalon-MM register port and byte addresses on word boundaries.
package sfds_pkg;

    // Register byte offsets
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFF_CTRL = 6'h00;
    localparam logic [5:0] OFF_INTEN = 6'h04;
    localparam logic [5:0] OFF_LEVEL = 6'h08;
    localparam logic [5:0] OFF_FLAG = 6'h0C;
    localparam logic [5:0] OFF_FMT0 = 6'h10;
    localparam logic [5:0] OFF_FMT1 = 6'h14;
    localparam logic [5:0] OFF_FMT2 = 6'h18;
    localparam logic [5:0] OFF_FMT3 = 6'h1C;
    localparam logic [5:0] OFF_TXDATA = 6'h20;
    localparam logic [5:0] OFF_RXBUF = 6'h24;
    localparam logic [5:0] OFF_VEC0 = 6'h28;
    localparam logic [5:0] OFF_VEC1 = 6'h2C;

    // Global control bits
    localparam int CTRL_MASTER = 0;
    localparam int CTRL_LOOPBACK = 1;
    localparam int CTRL_ENABLE = 2;

    // Event bit positions, shared by enable, level and flag registers
    localparam int EVT_BIT_MISMATCH_STATUS = 0;
    localparam int EVT_RX = 8;
    localparam int EVT_TX = 9;
    localparam int INTEN_DMA = 16;

    // Data format fields
    localparam int FMT_LEN_LSB = 0;
    localparam int FMT_LEN_W = 5;
    localparam int FMT_PRE_LSB = 8;
    localparam int FMT_PRE_W = 8;
    localparam int FMT_POL = 16;
    localparam int FMT_PHA = 17;
    localparam int FMT_ORDER = 20;
    localparam int NUM_FMT = 4;

    // Transmit and receive word fields
    localparam int DATA_W = 16;
    localparam int TX_FSEL_LSB = 24;
    localparam int RX_BIT_MISMATCH_STATUS = 28;
    localparam int RX_NEW = 31;

    // Character length limits
    localparam logic [4:0] CHAR_MIN = 5'h02;
    localparam logic [4:0] CHAR_MAX = 5'h10;

    // Shortest half period of the generated serial clock, in sys_clk cycles
    localparam logic [8:0] MIN_HALF = 9'h003;

    // Vector codes
    localparam logic [4:0] VEC_NONE = 5'h00;
    localparam logic [4:0] VEC_BIT_MISMATCH_STATUS = 5'h01;
    localparam logic [4:0] VEC_RX = 5'h02;
    localparam logic [4:0] VEC_TX = 5'h03;

    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] RST_FLAGS = 32'h0000_0200;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT
    } sfds_state_type;

endpackage : sfds_pkg

// ===== verif/sfds_core_asserts.sv
// Port-level checks for the SPI character engine.
// Assumes it is bound to sfds_core and sees only that module's ports.
module sfds_core_asserts
    import sfds_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic arst_n, // Reset, active low
    input wire logic [ADDR_W-1:0] avs_address, // Register address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [31:0] avs_readdata, // Read data
    input wire logic avs_waitrequest, // Stall
    input wire logic sclkOeN, // Clock enable
    input wire logic mosiOeN, // Master-out enable
    input wire logic misoOeN, // Master-in enable
    input wire logic irqLine0, // Line zero
    input wire logic irqLine1, // Line one
    input wire logic rxDmaReq, // Receive request
    input wire logic txDmaReq // Transmit request
);
    logic loopOn_ff;
    logic dmaOn_ff;
    logic [2:0] evtOn_ff;
    wire busWr = avs_write && !avs_waitrequest;
    wire rdDone = avs_read && !avs_waitrequest;

    // Shadow of the control bits, taken at the edge where a write lands
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            loopOn_ff <= 1'b0;
            dmaOn_ff <= 1'b0;
            evtOn_ff <= 3'b000;
        end else if (busWr && avs_address == OFF_CTRL) begin
            loopOn_ff <= avs_writedata[CTRL_LOOPBACK] & avs_writedata[CTRL_MASTER];
        end else if (busWr && avs_address == OFF_INTEN) begin
            dmaOn_ff <= avs_writedata[INTEN_DMA];
            evtOn_ff <= {avs_writedata[EVT_TX], avs_writedata[EVT_RX], avs_writedata[EVT_BIT_MISMATCH_STATUS]};
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    AST_RXBUF_PAD: assert property (rdDone && avs_address == OFF_RXBUF |-> avs_readdata[30:16] == 15'h0000 || avs_readdata[30:29] == 2'b00 && avs_readdata[27:16] == 12'h000)
        else $error("receive word has bits set above the data field");
    AST_VEC_CODE: assert property (rdDone && avs_address == OFF_VEC1 |-> avs_readdata[31:5] == 27'h0 && avs_readdata[4:0] <= VEC_TX)
        else $error("vector code out of range");
    AST_DMA_QUIET: assert property (!dmaOn_ff && !$past(dmaOn_ff) |-> !rxDmaReq && !txDmaReq)
        else $error("dma request while requests disabled");
    AST_TXDMA_PULSE: assert property (txDmaReq |=> !txDmaReq)
        else $error("transmit request longer than one cycle");
    AST_RXDMA_PULSE: assert property ($rose(rxDmaReq) |=> $fell(rxDmaReq))
        else $error("receive request longer than one cycle");
    AST_LOOP_PINS: assert property (loopOn_ff && $past(loopOn_ff) |-> sclkOeN && mosiOeN && misoOeN)
        else $error("pin driven during loopback");
    AST_OE_PAIR: assert property (sclkOeN == mosiOeN)
        else $error("clock and data enables disagree");
    AST_IRQ_MASKED: assert property (evtOn_ff == 3'b000 && $past(evtOn_ff) == 3'b000 |-> !irqLine0 && !irqLine1)
        else $error("interrupt with all events disabled");
endmodule : sfds_core_asserts

bind sfds_core sfds_core_asserts u_sfds_core_asserts (.sys_clk, .arst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .sclkOeN, .mosiOeN, .misoOeN, .irqLine0, .irqLine1,
    .rxDmaReq, .txDmaReq);

// ===== verif/sfds_slave_model.sv
// Behavioural SPI slave on the far side of the serial pins.
// Assumes the bench arms it with the format in use before each character.
module sfds_slave_model (
    input wire logic sclk, // Serial clock wire
    input wire logic mosi, // Master-out wire
    input wire logic arm, // Rising edge starts a character
    input wire logic pol, // Clock idle level
    input wire logic pha, // Clock phase
    input wire logic lsbFirst, // Bit order
    input wire logic [4:0] len, // Character length
    input wire logic [15:0] txWord, // Word sent back
    output logic miso, // Master-in drive
    output logic misoEn, // Drives master-in when high
    output logic [15:0] rxWord // Word captured
);
    timeunit 1ns;
    timeprecision 1ps;
    int idx;
    int capCnt;
    logic started;

    function automatic logic outBit(input int i);
        return lsbFirst ? txWord[i] : txWord[len - 1 - i];
    endfunction : outBit

    initial begin
        miso = 1'b0;
        misoEn = 1'b0;
        rxWord = '0;
    end

    always @(posedge arm) begin
        rxWord = '0;
        capCnt = 0;
        started = 1'b0;
        misoEn = 1'b1;
        idx = pha ? 1 : 0;
        miso = pha ? outBit(0) : ~miso;
    end

    // The idle-level change at character start is not a clock edge
    always @(sclk) begin
        if (misoEn && (started || sclk != pol)) begin
            started = 1'b1;
            if (sclk == (pol ^ pha)) begin
                if (lsbFirst) begin
                    rxWord[capCnt] = mosi;
                end else begin
                    rxWord = {rxWord[14:0], mosi};
                end
                capCnt++;
            end else begin
                miso = (idx < len) ? outBit(idx) : ~miso;
                idx++;
            end
        end
    end
endmodule : sfds_slave_model

// ===== verif/testbench.sv
// Self-checking bench for the SPI character engine, master role.
// Assumes pins resolve with pull-ups and the slave model on the far side.
module testbench
    import sfds_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sysClk = 0, arstN = 0, avsRead = 0, avsWrite = 0, stuck = 0, arm = 0;
    logic [5:0] avsAddress = '0;
    logic [31:0] avsWritedata = '0;
    logic [31:0] avsReaddata;
    logic avsWaitrequest, sclkOut, sclkOeN, mosiOut, mosiOeN, misoOut, misoOeN, irqLine0, irqLine1, rxDmaReq, txDmaReq;
    logic mPol = 0, mPha = 0, mLsb = 0, mMiso, mMisoEn;
    logic [4:0] mLen = 5'h10;
    logic [15:0] mTx = '0;
    logic [15:0] mRx;
    int err_count = 0, checks = 0, cycles = 0, txCnt = 0, rxCnt = 0;
    int lenT[4] = '{16, 10, 5, 2};
    logic lsbT[4] = '{0, 1, 0, 1};
    logic [15:0] datT[4] = '{16'hA5C3, 16'h03A2, 16'h0013, 16'h0002};
    // Stuck forces the master-out wire high to provoke a compare fault
    wire sclkW = sclkOeN ? 1'b1 : sclkOut;
    wire mosiW = (stuck || mosiOeN) ? 1'b1 : mosiOut;
    wire misoW = !misoOeN ? misoOut : (mMisoEn ? mMiso : 1'b1);

    always #4 sysClk = ~sysClk;

    sfds_core u_sfds_core (.sys_clk(sysClk), .arst_n(arstN), .avs_address(avsAddress), .avs_read(avsRead),
        .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(4'hF), .avs_readdata(avsReaddata),
        .avs_waitrequest(avsWaitrequest), .sclkIn(sclkW), .sclkOut, .sclkOeN, .mosiIn(mosiW), .mosiOut, .mosiOeN,
        .misoIn(misoW), .misoOut, .misoOeN, .irqLine0, .irqLine1, .rxDmaReq, .txDmaReq);
    sfds_slave_model u_sfds_slave_model (.sclk(sclkW), .mosi(mosiW), .arm, .pol(mPol), .pha(mPha),
        .lsbFirst(mLsb), .len(mLen), .txWord(mTx), .miso(mMiso), .misoEn(mMisoEn), .rxWord(mRx));

    always @(posedge sysClk) begin
        cycles++;
        txCnt += (txDmaReq === 1'b1);
        rxCnt += (rxDmaReq === 1'b1);
        if (cycles == 30000) begin
            err_count++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sysClk);
        avsAddress <= a;
        avsWritedata <= d;
        avsWrite <= wr;
        avsRead <= !wr;
        do @(posedge sysClk);
        while (avsWaitrequest !== 1'b0);
        q = avsReaddata;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rdchk(input string nm, input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(nm, e, q & m);
    endtask : rdchk

    // One character, then wait for receive full
    task automatic xfer(input int f, input logic [15:0] d, input logic [15:0] s);
        logic [31:0] q;
        mPol <= f[0];
        mPha <= f[1];
        mLsb <= lsbT[f];
        mLen <= 5'(lenT[f]);
        mTx <= s;
        @(posedge sysClk);
        arm <= 1'b1;
        @(posedge sysClk);
        arm <= 1'b0;
        wr(OFF_TXDATA, {6'h00, 2'(f), 8'h00, d});
        q = '0;
        while (q[EVT_RX] !== 1'b1) begin
            bus(1'b0, OFF_FLAG, 32'h0000_0000, q);
        end
    endtask : xfer

    initial begin
        logic [15:0] mask;
        repeat (6) @(posedge sysClk);
        arstN <= 1'b1;
        rdchk("flag reset", OFF_FLAG, 32'hFFFF_FFFF, RST_FLAGS);
        rdchk("unmapped", 6'h30, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(OFF_CTRL, 32'h0000_0005);
        wr(OFF_INTEN, 32'h0000_0100);
        wr(OFF_LEVEL, 32'h0000_0100);
        for (int i = 0; i < 4; i++) begin
            mask = 16'((32'h1 << lenT[i]) - 1);
            wr(OFF_FMT0 + 6'(4 * i), 32'(lenT[i] | 32'h0000_0100 | (i[0] << FMT_POL) | (i[1] << FMT_PHA)
                | (lsbT[i] << FMT_ORDER)));
            xfer(i, datT[i], ~datT[i]);
            chk("line one", 32'h1, irqLine1);
            chk("line zero", 32'h0, irqLine0);
            rdchk("vector", OFF_VEC1, 32'h0000_001F, {27'h0, VEC_RX});
            rdchk("rx word", OFF_RXBUF, 32'hFFFF_FFFF, {16'h8000, ~datT[i] & mask});
            chk("slave word", {16'h0, datT[i] & mask}, {16'h0, mRx});
            $display("mode %0d test done", i);
        end
        chk("dma idle", 32'h0, 32'(txCnt + rxCnt));
        wr(OFF_INTEN, 32'h0001_0000);
        xfer(0, 16'h1234, 16'h4321);
        chk("line one masked", 32'h0, irqLine1);
        rdchk("dma rx word", OFF_RXBUF, 32'h0000_FFFF, 32'h0000_4321);
        chk("rx requests", 32'h1, 32'(rxCnt));
        chk("tx requests", 32'h2, 32'(txCnt));
        $display("dma test done");
        wr(OFF_INTEN, 32'h0000_0001);
        stuck <= 1'b1;
        xfer(0, 16'h0000, 16'h0000);
        chk("error line", 32'h1, irqLine0);
        rdchk("error flag", OFF_FLAG, 32'h0000_0001, 32'h0000_0001);
        rdchk("error status", OFF_RXBUF, 32'h9000_0000, 32'h9000_0000);
        wr(OFF_FLAG, 32'h0000_0001);
        rdchk("flag cleared", OFF_FLAG, 32'h0000_0001, 32'h0000_0000);
        $display("compare test done");
        wr(OFF_CTRL, 32'h0000_0007);
        xfer(1, 16'h0155, 16'h0000);
        chk("pins released", 32'h7, {29'h0, sclkOeN, mosiOeN, misoOeN});
        rdchk("loop word", OFF_RXBUF, 32'hFFFF_FFFF, 32'h8000_0155);
        $display("loopback test done");
        results();
    end
endmodule : testbench
